// >>> evct_pkg.sv
// Function
// - event pin edges counted, compare0 match raises
// - later matches every compare0 plus one edges
// - first match after compare0 plus two edges
// - edge valid after two equal consecutive samples
// - compare1 match still raises its interrupt
// - mode zero stops and clears counter
// - edge-clear mode: edge zeroes, else wraps
// - edge-clear mode counts at once on entry
// - compare registers match counter, raise interrupts
// - register0 captures on capture pin or opposite
// - register1 captures on event edge; edge-clear mode then clears counter
// - toggle bit adds event edge output toggling
// - opposite-phase capture into register0 without interrupt
// - mode three clears counter on compare0 match
package evct_pkg;
    // byte addresses of the word registers
    localparam logic [4:0] OFS_CNT  = 5'h00;
    localparam logic [4:0] OFS_CR0  = 5'h04;
    localparam logic [4:0] OFS_CR1  = 5'h08;
    localparam logic [4:0] OFS_MODE = 5'h0C;
    localparam logic [4:0] OFS_CRC  = 5'h10;
    localparam logic [4:0] OFS_PRM  = 5'h14;
    localparam logic [4:0] OFS_OUT  = 5'h18;
    // field positions
    localparam int MODE_LO    = 2;
    localparam int MODE_TGL   = 1;
    localparam int CRC_CAP0   = 0;
    localparam int CRC_REV    = 1;
    localparam int CRC_CAP1   = 2;
    localparam int PRM_SEL_LO = 0;
    localparam int PRM_EVT_LO = 4;
    localparam int PRM_CAP_LO = 6;
    localparam int OUT_LVL    = 1;
    // reset values
    localparam logic [15:0] RST_CR  = 16'h0000;
    localparam logic [7:0]  RST_REG = 8'h00;
    // operating modes
    localparam logic [1:0] MODE_STOP  = 2'h0;
    localparam logic [1:0] MODE_FREE  = 2'h1;
    localparam logic [1:0] MODE_EDGE  = 2'h2;
    localparam logic [1:0] MODE_MATCH = 2'h3;
    // count clock selections beyond the divider taps
    localparam logic [2:0] SEL_EVENT = 3'h6;
    localparam logic [2:0] SEL_EXT   = 3'h7;
    // edge selections
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_NONE = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // prescaler divider width
    localparam int DIV_W = 5;
    // bus handshake states
    typedef enum logic [1:0] {
        EVCT_BUS_IDLE = 2'b01,
        EVCT_BUS_ACK  = 2'b10
    } evct_bus_e;
endpackage : evct_pkg

// >>> evct_edge_filter.sv
`timescale 1ns/1ns
`default_nettype none
module evct_edge_filter (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       pin,
    input  wire logic [1:0] edge_sel,
    output logic            valid_edge,
    output logic            opp_edge
);
    logic sync1_ff;
    logic sync2_ff;
    logic samp_ff;
    logic lvl_ff;
    logic rise_ff;
    logic fall_ff;
    logic take;

    // level accepted once two samples agree
    assign take = (sync2_ff == samp_ff) && (sync2_ff != lvl_ff);

    // synchroniser, sample history and filtered level
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            samp_ff  <= 1'b0;
            lvl_ff   <= 1'b0;
            rise_ff  <= 1'b0;
            fall_ff  <= 1'b0;
        end
        else
        begin
            sync1_ff <= pin;
            sync2_ff <= sync1_ff;
            samp_ff  <= sync2_ff;
            if (take)
                lvl_ff <= sync2_ff;
            rise_ff  <= take & sync2_ff;
            fall_ff  <= take & ~sync2_ff;
        end
    end

    // edge selection and its opposite phase
    assign valid_edge = (edge_sel == evct_pkg::EDGE_RISE) ? rise_ff :
                        (edge_sel == evct_pkg::EDGE_FALL) ? fall_ff :
                        (edge_sel == evct_pkg::EDGE_BOTH) ?
                        (rise_ff | fall_ff) : 1'b0;
    assign opp_edge   = (edge_sel == evct_pkg::EDGE_RISE) ? fall_ff :
                        (edge_sel == evct_pkg::EDGE_FALL) ? rise_ff :
                        1'b0;

    property p_filter_rise;
        @(posedge mclk) disable iff (rst)
        rise_ff |-> $past(sync2_ff) && $past(sync2_ff, 2);
    endproperty
    a_filter_rise : assert property (p_filter_rise)
        else $error("rise accepted without two high samples");

    property p_filter_fall;
        @(posedge mclk) disable iff (rst)
        fall_ff |-> !$past(sync2_ff) && !$past(sync2_ff, 2);
    endproperty
    a_filter_fall : assert property (p_filter_fall)
        else $error("fall accepted without two low samples");
endmodule : evct_edge_filter
`default_nettype wire

// >>> evct_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
module evct_prescaler #(
    parameter int DIVW = evct_pkg::DIV_W
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [2:0] sel,
    input  wire logic       evt_tick,
    input  wire logic       ext_tick,
    output logic            tick
);
    logic [DIVW-1:0] div_ff;
    logic [DIVW-1:0] low_mask;
    logic            div_hit;

    // free-running divider for the power-of-two taps
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            div_ff <= '0;
        else
            div_ff <= div_ff + 1'b1;
    end

    // tap n fires once every 2**n cycles
    assign low_mask = ~({DIVW{1'b1}} << sel);
    assign div_hit  = (div_ff & low_mask) == low_mask;
    assign tick     = (sel == evct_pkg::SEL_EVENT) ? evt_tick :
                      (sel == evct_pkg::SEL_EXT)   ? ext_tick :
                      div_hit;
endmodule : evct_prescaler
`default_nettype wire

// >>> evct_timer.sv
`timescale 1ns/1ns
`default_nettype none
module evct_timer (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        event_in_pin,
    input  wire logic        capture_in_pin,
    input  wire logic        ext_tick,
    output logic             match0_irq,
    output logic             match1_irq,
    output logic             timer_out_pin
);
    evct_pkg::evct_bus_e bus_ff;
    evct_pkg::evct_bus_e nxt_bus;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [15:0] up_counter_ff;
    logic [15:0] nxt_up_counter;
    logic [15:0] capcmp_reg0_ff;
    logic [15:0] nxt_capcmp_reg0;
    logic [15:0] capcmp_reg1_ff;
    logic [15:0] nxt_capcmp_reg1;
    logic [7:0]  timer_mode_ctrl_reg_ff;
    logic [7:0]  capcmp_ctrl_reg_ff;
    logic [7:0]  prescaler_mode_reg_ff;
    logic        lvl_ff;
    logic        nxt_lvl;
    logic        started_ff;
    logic        nxt_started;
    logic        irq0_ff;
    logic        irq1_ff;
    logic        req;
    logic        commit;
    logic        wr_cr0;
    logic        wr_cr1;
    logic        wr_mode;
    logic        wr_crc;
    logic        wr_prm;
    logic        wr_out;
    logic [15:0] wmask;
    logic [1:0]  op_mode;
    logic        edge_toggle_enable;
    logic        cap0_mode;
    logic        cap1_mode;
    logic        reverse_phase_capture_sel;
    logic [2:0]  count_clock_sel;
    logic        evt_valid;
    logic        evt_opp;
    logic        cap_valid;
    logic        tick;
    logic        run;
    logic        cnt_tick;
    logic        edge_clr;
    logic        m0_hit;
    logic        m1_hit;
    logic        cap0_take;
    logic        cap1_take;
    logic        irq0;
    logic        irq1;
    logic        toggle;

    // control fields
    assign op_mode            = timer_mode_ctrl_reg_ff[evct_pkg::MODE_LO+:2];
    assign edge_toggle_enable = timer_mode_ctrl_reg_ff[evct_pkg::MODE_TGL];
    assign cap0_mode          = capcmp_ctrl_reg_ff[evct_pkg::CRC_CAP0] &
                                (op_mode != evct_pkg::MODE_MATCH);
    assign reverse_phase_capture_sel =
                                capcmp_ctrl_reg_ff[evct_pkg::CRC_REV];
    assign cap1_mode          = capcmp_ctrl_reg_ff[evct_pkg::CRC_CAP1];
    assign count_clock_sel    =
        prescaler_mode_reg_ff[evct_pkg::PRM_SEL_LO+:3];

    // filtered edges of the event and capture pins
    evct_edge_filter u_evt_filter (
        .mclk       (mclk),
        .rst        (rst),
        .pin        (event_in_pin),
        .edge_sel   (prescaler_mode_reg_ff[evct_pkg::PRM_EVT_LO+:2]),
        .valid_edge (evt_valid),
        .opp_edge   (evt_opp)
    );

    evct_edge_filter u_cap_filter (
        .mclk       (mclk),
        .rst        (rst),
        .pin        (capture_in_pin),
        .edge_sel   (prescaler_mode_reg_ff[evct_pkg::PRM_CAP_LO+:2]),
        .valid_edge (cap_valid),
        .opp_edge   ()
    );

    // count clock: divider tap, event edge or external tick
    evct_prescaler #(
        .DIVW (evct_pkg::DIV_W)
    ) u_prescaler (
        .mclk     (mclk),
        .rst      (rst),
        .sel      (count_clock_sel),
        .evt_tick (evt_valid),
        .ext_tick (ext_tick),
        .tick     (tick)
    );

    // bus handshake: one wait cycle, commit on the second
    assign req             = avs_read | avs_write;
    assign commit          = req & (bus_ff == evct_pkg::EVCT_BUS_ACK);
    assign avs_waitrequest = req & ~commit;
    assign avs_readdata    = rdata_ff;
    assign nxt_bus         = commit ? evct_pkg::EVCT_BUS_IDLE :
                             req    ? evct_pkg::EVCT_BUS_ACK  :
                             evct_pkg::EVCT_BUS_IDLE;

    // write decode and byte lanes
    assign wr_cr0  = avs_write & commit & (avs_address == evct_pkg::OFS_CR0);
    assign wr_cr1  = avs_write & commit & (avs_address == evct_pkg::OFS_CR1);
    assign wr_mode = avs_write & commit & avs_byteenable[0] &
                     (avs_address == evct_pkg::OFS_MODE);
    assign wr_crc  = avs_write & commit & avs_byteenable[0] &
                     (avs_address == evct_pkg::OFS_CRC);
    assign wr_prm  = avs_write & commit & avs_byteenable[0] &
                     (avs_address == evct_pkg::OFS_PRM);
    assign wr_out  = avs_write & commit & avs_byteenable[0] &
                     (avs_address == evct_pkg::OFS_OUT);
    assign wmask   = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // read mux, unmapped reads as zero
    assign nxt_rdata =
        (avs_address == evct_pkg::OFS_CNT)  ? {16'h0000, up_counter_ff} :
        (avs_address == evct_pkg::OFS_CR0)  ? {16'h0000, capcmp_reg0_ff} :
        (avs_address == evct_pkg::OFS_CR1)  ? {16'h0000, capcmp_reg1_ff} :
        (avs_address == evct_pkg::OFS_MODE) ?
            {24'h000000, timer_mode_ctrl_reg_ff} :
        (avs_address == evct_pkg::OFS_CRC)  ?
            {24'h000000, capcmp_ctrl_reg_ff} :
        (avs_address == evct_pkg::OFS_PRM)  ?
            {24'h000000, prescaler_mode_reg_ff} :
        (avs_address == evct_pkg::OFS_OUT)  ?
            {30'h00000000, lvl_ff, 1'b0} :
        32'h00000000;

    // counting qualifiers; mode three skips its first count clock
    assign run      = op_mode != evct_pkg::MODE_STOP;
    assign cnt_tick = tick & run &
                      (started_ff | (op_mode != evct_pkg::MODE_MATCH));
    assign nxt_started = run & (started_ff | tick);
    assign edge_clr = (op_mode == evct_pkg::MODE_EDGE) & evt_valid;

    // compare matches on the count clock
    assign m0_hit = cnt_tick & ~cap0_mode &
                    (up_counter_ff == capcmp_reg0_ff);
    assign m1_hit = cnt_tick & ~cap1_mode &
                    (up_counter_ff == capcmp_reg1_ff);

    // next count value
    assign nxt_up_counter =
        !run     ? evct_pkg::RST_CR :
        edge_clr ? evct_pkg::RST_CR :
        ((op_mode == evct_pkg::MODE_MATCH) & m0_hit) ?
            evct_pkg::RST_CR :
        cnt_tick ? up_counter_ff + 16'h0001 :
        up_counter_ff;

    // capture triggers and interrupt causes
    assign cap0_take = run & cap0_mode &
                       (reverse_phase_capture_sel ? evt_opp
                                                  : cap_valid);
    assign cap1_take = run & cap1_mode & evt_valid;
    assign irq0 = m0_hit | (run & cap0_mode & cap_valid);
    assign irq1 = m1_hit | cap1_take;

    // capture beats a software write in the same cycle
    assign nxt_capcmp_reg0 = cap0_take ? up_counter_ff :
        wr_cr0 ? ((capcmp_reg0_ff & ~wmask) | (avs_writedata[15:0] & wmask))
               : capcmp_reg0_ff;
    assign nxt_capcmp_reg1 = cap1_take ? up_counter_ff :
        wr_cr1 ? ((capcmp_reg1_ff & ~wmask) | (avs_writedata[15:0] & wmask))
               : capcmp_reg1_ff;

    // output toggles on matches, optionally on event edges
    assign toggle  = m0_hit | m1_hit |
                     (edge_toggle_enable & evt_valid & run);
    assign nxt_lvl = (wr_out ? avs_writedata[evct_pkg::OUT_LVL] : lvl_ff)
                     ^ toggle;

    // bus state and read data
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            bus_ff   <= evct_pkg::EVCT_BUS_IDLE;
            rdata_ff <= 32'h00000000;
        end
        else
        begin
            bus_ff   <= nxt_bus;
            rdata_ff <= nxt_rdata;
        end
    end

    // control registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            timer_mode_ctrl_reg_ff <= evct_pkg::RST_REG;
            capcmp_ctrl_reg_ff     <= evct_pkg::RST_REG;
            prescaler_mode_reg_ff  <= evct_pkg::RST_REG;
        end
        else
        begin
            if (wr_mode)
                timer_mode_ctrl_reg_ff <= avs_writedata[7:0];
            if (wr_crc)
                capcmp_ctrl_reg_ff <= avs_writedata[7:0];
            if (wr_prm)
                prescaler_mode_reg_ff <= avs_writedata[7:0];
        end
    end

    // counter, capture registers, output level and pulses
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            up_counter_ff  <= evct_pkg::RST_CR;
            capcmp_reg0_ff <= evct_pkg::RST_CR;
            capcmp_reg1_ff <= evct_pkg::RST_CR;
            started_ff     <= 1'b0;
            lvl_ff         <= 1'b0;
            irq0_ff        <= 1'b0;
            irq1_ff        <= 1'b0;
        end
        else
        begin
            up_counter_ff  <= nxt_up_counter;
            capcmp_reg0_ff <= nxt_capcmp_reg0;
            capcmp_reg1_ff <= nxt_capcmp_reg1;
            started_ff     <= nxt_started;
            lvl_ff         <= nxt_lvl;
            irq0_ff        <= irq0;
            irq1_ff        <= irq1;
        end
    end

    assign match0_irq    = irq0_ff;
    assign match1_irq    = irq1_ff;
    assign timer_out_pin = lvl_ff;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    property p_stop_clear;
        op_mode == evct_pkg::MODE_STOP |=> up_counter_ff == 16'h0000;
    endproperty
    a_stop_clear : assert property (p_stop_clear)
        else $error("stopped counter not cleared");

    property p_match_clear;
        (op_mode == evct_pkg::MODE_MATCH) && cnt_tick && ~cap0_mode &&
        (up_counter_ff == capcmp_reg0_ff) |=>
        (up_counter_ff == 16'h0000) && match0_irq;
    endproperty
    a_match_clear : assert property (p_match_clear)
        else $error("compare0 match did not clear and interrupt");

    property p_start_skip;
        (op_mode == evct_pkg::MODE_MATCH) && !started_ff && tick
        |=> up_counter_ff == $past(up_counter_ff);
    endproperty
    a_start_skip : assert property (p_start_skip)
        else $error("first count clock was counted");

    property p_edge_clear;
        (op_mode == evct_pkg::MODE_EDGE) && evt_valid
        |=> up_counter_ff == 16'h0000;
    endproperty
    a_edge_clear : assert property (p_edge_clear)
        else $error("event edge did not clear counter");

    property p_edge_count;
        (op_mode == evct_pkg::MODE_EDGE) && tick && !evt_valid
        |=> up_counter_ff == $past(up_counter_ff) + 16'h0001;
    endproperty
    a_edge_count : assert property (p_edge_count)
        else $error("edge-clear mode did not count");

    property p_cap1;
        run && cap1_mode && evt_valid |=>
        (capcmp_reg1_ff == $past(up_counter_ff)) && match1_irq;
    endproperty
    a_cap1 : assert property (p_cap1)
        else $error("register1 capture missing");

    property p_cap0;
        run && cap0_mode && cap_valid && !reverse_phase_capture_sel |=>
        (capcmp_reg0_ff == $past(up_counter_ff)) && match0_irq;
    endproperty
    a_cap0 : assert property (p_cap0)
        else $error("register0 capture missing");

    property p_rev_quiet;
        run && cap0_mode && reverse_phase_capture_sel && evt_opp &&
        !cap_valid |=> (capcmp_reg0_ff == $past(up_counter_ff)) &&
        !match0_irq;
    endproperty
    a_rev_quiet : assert property (p_rev_quiet)
        else $error("reverse-phase capture raised interrupt");

    property p_cmp1;
        cnt_tick && !cap1_mode && (up_counter_ff == capcmp_reg1_ff)
        |=> match1_irq;
    endproperty
    a_cmp1 : assert property (p_cmp1)
        else $error("compare1 match without interrupt");

    property p_edge_toggle;
        edge_toggle_enable && evt_valid && run && !m0_hit && !m1_hit &&
        !wr_out |=> timer_out_pin != $past(timer_out_pin);
    endproperty
    a_edge_toggle : assert property (p_edge_toggle)
        else $error("event edge did not toggle output");

    c_match0 : cover property (m0_hit ##1 match0_irq);
    c_edge_clr : cover property (edge_clr && up_counter_ff != 16'h0000);
    c_cap1 : cover property (cap1_take ##1 match1_irq);
    c_rev : cover property (cap0_take && reverse_phase_capture_sel);
endmodule : evct_timer
`default_nettype wire

// >>> evct_pulse_src.sv
`timescale 1ns/1ns
`default_nettype none
// external pulse source on the event and capture pins
module evct_pulse_src (
    input  wire logic mclk,
    output logic      event_in_pin,
    output logic      capture_in_pin
);
    // both pins rest low between pulses
    initial
    begin
        event_in_pin   = 1'b0;
        capture_in_pin = 1'b0;
    end

    // put one pin at a level and keep it there for hold cycles
    task automatic set_pin(input bit cap, input logic lvl, input int hold);
        @(posedge mclk);
        if (cap)
            capture_in_pin <= lvl;
        else
            event_in_pin <= lvl;
        repeat (hold - 1) @(posedge mclk);
    endtask : set_pin

    // one high pulse; one cycle high is a glitch the filter must drop
    task automatic pulse(input bit cap, input int hi, input int lo);
        set_pin(cap, 1'b1, hi);
        set_pin(cap, 1'b0, lo);
    endtask : pulse
endmodule : evct_pulse_src
`default_nettype wire

// >>> tb_event_counter_edge_clear_timer.sv
`timescale 1ns/1ns
`default_nettype none
module tb_event_counter_edge_clear_timer;
    logic        mclk;
    logic        rst;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        event_in_pin;
    logic        capture_in_pin;
    logic        ext_tick;
    logic        match0_irq;
    logic        match1_irq;
    logic        timer_out_pin;
    logic        out_prev;
    logic [31:0] exp_q[$];
    logic [31:0] lfsr;
    logic [15:0] rnd;
    int          fail_count;
    int          tests_run;
    int          n_m0;
    int          n_m1;
    int          n_tgl;

    // 125 MHz clock
    initial mclk = 1'b0;
    always #4 mclk = ~mclk;

    evct_timer uut (
        .mclk(mclk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .event_in_pin(event_in_pin), .capture_in_pin(capture_in_pin),
        .ext_tick(ext_tick), .match0_irq(match0_irq),
        .match1_irq(match1_irq), .timer_out_pin(timer_out_pin)
    );

    evct_pulse_src src (
        .mclk(mclk), .event_in_pin(event_in_pin),
        .capture_in_pin(capture_in_pin)
    );

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next

    // counts and verdict, the single place the run ends
    task automatic finish_test;
        // a read note never answered counts as a mismatch
        if (exp_q.size() != 0)
            fail_count++;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    task automatic check_rd(input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch readdata expected %h seen %h", exp, got);
        end
    endtask : check_rd

    task automatic check_cnt(input string what, input int exp, input int got);
        tests_run++;
        if (got != exp)
        begin
            fail_count++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_cnt

    // one avalon access, held until waitrequest is seen low
    task automatic bus_req(input logic wr, input logic [4:0] a,
                           input logic [31:0] d);
        int i;
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= ~wr;
        avs_write     <= wr;
        for (i = 0; i < 20; i++)
        begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        if (i == 20)
        begin
            fail_count++;
            finish_test();
        end
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask : bus_req

    task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
        bus_req(1'b1, a, d);
    endtask : bus_wr

    task automatic bus_rd(input logic [4:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        bus_req(1'b0, a, 32'h0);
    endtask : bus_rd

    // single-cycle count clock pulses
    task automatic tick(input int n);
        repeat (n)
        begin
            ext_tick <= 1'b1;
            @(posedge mclk);
            ext_tick <= 1'b0;
            @(posedge mclk);
        end
    endtask : tick

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask : idle

    // monitor: read data against oldest note, pulse and toggle counts
    always @(posedge mclk)
    begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
            check_rd(exp_q.pop_front(), avs_readdata);
        if (match0_irq === 1'b1)
            n_m0++;
        if (match1_irq === 1'b1)
            n_m1++;
        if (timer_out_pin !== out_prev)
            n_tgl++;
        out_prev <= timer_out_pin;
    end

    // hang guard
    initial
    begin
        #200000;
        fail_count++;
        finish_test();
    end

    // main sequence
    initial
    begin
        rst = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        ext_tick = 1'b0;
        out_prev = 1'b0;
        lfsr = 32'h2338;
        fail_count = 0;
        tests_run = 0;
        n_m0 = 0;
        n_m1 = 0;
        n_tgl = 0;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        // reset values, unmapped slot, random readback
        for (int a = 0; a < 8; a++)
            bus_rd(5'(a * 4), 32'h0);
        repeat (4)
        begin
            lfsr = lfsr_next(lfsr);
            rnd  = lfsr[15:0] | 16'h0001;
            bus_wr(evct_pkg::OFS_CR0, {16'h0, rnd});
            bus_wr(evct_pkg::OFS_CR1, {16'h0, ~rnd});
            bus_rd(evct_pkg::OFS_CR0, {16'h0, rnd});
            bus_rd(evct_pkg::OFS_CR1, {16'h0, ~rnd});
        end
        bus_wr(5'h1C, 32'hFFFF);
        bus_rd(5'h1C, 32'h0);
        // output level written and read back, then parked low
        bus_wr(evct_pkg::OFS_OUT, 32'h2);
        bus_rd(evct_pkg::OFS_OUT, 32'h2);
        bus_wr(evct_pkg::OFS_OUT, 32'h0);
        bus_rd(evct_pkg::OFS_OUT, 32'h0);
        $display("test registers done");
        // event counting, compare0 of two
        bus_wr(evct_pkg::OFS_CR0, 32'h2);
        bus_wr(evct_pkg::OFS_CR1, 32'h1);
        bus_wr(evct_pkg::OFS_PRM, 32'h16);
        n_m0 = 0;
        n_m1 = 0;
        bus_wr(evct_pkg::OFS_MODE, 32'hC);
        repeat (4) src.pulse(1'b0, 4, 4);
        idle(6);
        check_cnt("first match0", 1, n_m0);
        repeat (2) src.pulse(1'b0, 4, 4);
        src.pulse(1'b0, 1, 6);
        idle(6);
        check_cnt("glitch match0", 1, n_m0);
        src.pulse(1'b0, 4, 4);
        idle(6);
        check_cnt("next match0", 2, n_m0);
        check_cnt("event match1", 2, n_m1);
        src.pulse(1'b0, 4, 4);
        idle(6);
        bus_rd(evct_pkg::OFS_CNT, 32'h1);
        bus_wr(evct_pkg::OFS_MODE, 32'h0);
        bus_rd(evct_pkg::OFS_CNT, 32'h0);
        $display("test event counting done");
        // edge-clear mode with two compares on ext_tick
        bus_wr(evct_pkg::OFS_CR0, 32'h3);
        bus_wr(evct_pkg::OFS_CR1, 32'h4);
        bus_wr(evct_pkg::OFS_CRC, 32'h0);
        bus_wr(evct_pkg::OFS_PRM, 32'h17);
        n_m0 = 0;
        n_m1 = 0;
        bus_wr(evct_pkg::OFS_MODE, 32'h8);
        tick(5);
        idle(3);
        check_cnt("compare match0", 1, n_m0);
        check_cnt("compare match1", 1, n_m1);
        bus_rd(evct_pkg::OFS_CNT, 32'h5);
        n_tgl = 0;
        src.pulse(1'b0, 4, 4);
        idle(6);
        bus_rd(evct_pkg::OFS_CNT, 32'h0);
        check_cnt("toggles off", 0, n_tgl);
        bus_wr(evct_pkg::OFS_MODE, 32'hA);
        n_tgl = 0;
        repeat (3) src.pulse(1'b0, 4, 4);
        idle(6);
        check_cnt("toggles on", 3, n_tgl);
        $display("test edge clear compare done");
        // edge-clear mode with both registers capturing
        bus_wr(evct_pkg::OFS_MODE, 32'h0);
        bus_wr(evct_pkg::OFS_PRM, 32'h57);
        bus_wr(evct_pkg::OFS_CRC, 32'h5);
        bus_wr(evct_pkg::OFS_MODE, 32'h8);
        n_m0 = 0;
        n_m1 = 0;
        tick(5);
        src.pulse(1'b0, 4, 4);
        idle(6);
        bus_rd(evct_pkg::OFS_CR1, 32'h5);
        bus_rd(evct_pkg::OFS_CNT, 32'h0);
        check_cnt("capture match1", 1, n_m1);
        tick(3);
        src.pulse(1'b1, 4, 4);
        idle(6);
        bus_rd(evct_pkg::OFS_CR0, 32'h3);
        check_cnt("capture match0", 1, n_m0);
        bus_wr(evct_pkg::OFS_CRC, 32'h7);
        src.set_pin(1'b0, 1'b1, 8);
        tick(4);
        src.set_pin(1'b0, 1'b0, 8);
        bus_rd(evct_pkg::OFS_CR1, 32'h3);
        bus_rd(evct_pkg::OFS_CR0, 32'h4);
        check_cnt("reverse match0", 1, n_m0);
        check_cnt("reverse match1", 2, n_m1);
        src.pulse(1'b1, 4, 4);
        idle(6);
        check_cnt("pin match0", 2, n_m0);
        bus_rd(evct_pkg::OFS_CR0, 32'h4);
        $display("test capture done");
        finish_test();
    end
endmodule : tb_event_counter_edge_clear_timer
`default_nettype wire
